// ---- verilog/cdmp_core_end.sv ----
// Purpose: core end of the data memory port with its command fifo
// Assumes: memory end and user logic share i_ref_clk, so no synchronisers
// Notes: one fifo entry is one beat; bursts are runs of entries with more set
`timescale 1ns/1ps
`default_nettype none

// queue with parameter width and depth, registered full and empty
module cdmp_fifo #(
    parameter int WIDTH = cdmp_pkg::CMD_W,
    parameter int DEPTH = cdmp_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    // fill side
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    // drain side
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int PTR_W = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PTR_W-1:0] wr_ptr_reg;
    logic [PTR_W-1:0] rd_ptr_reg;
    logic [PTR_W:0] count_reg;
    logic push;
    logic pop;

    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;
    assign o_out_data = mem_reg[rd_ptr_reg];

    // storage writes
    always_ff @(posedge i_ref_clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= i_in_data;
        end
    end

    // pointers, count and flags
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
            o_in_ready <= 1'b1;
            o_out_valid <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
                o_in_ready <= (count_reg != (PTR_W+1)'(DEPTH - 1));
                o_out_valid <= 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
                o_in_ready <= 1'b1;
                o_out_valid <= (count_reg != (PTR_W+1)'(1));
            end
        end
    end
endmodule

// Function
// - 32-bit byte address per data access
// - request low announces next-cycle access
// - direction flag: low read, high write
// - read data only on reads, write on writes
// - size codes 00/01/10, never 11
// - sequential flag for continuing beats
// - burst-continue when next beat follows sequentially
// - lock held; memory grants nobody else meanwhile
// - speculative hint marks address maybe needed later
// - memory never aborts a speculative hint
// - hint never with request in same cycle
// - privilege flag low user, high supervisor
// - five-bit mode valid with the address
// - cancel flag drops previous cycle request
// - four-bit burst length of current burst
// - memory aborts accesses not permitted
// - watchpoint at request end halts core
// - everything changes and samples on rising edge
// - memory stalls whole cycles via stall enable
module cdmp_core_end #(
    parameter int DEPTH = cdmp_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    // command queue from user logic
    input wire logic i_cmd_valid,
    output logic o_cmd_ready,
    input wire cdmp_pkg::cdmp_cmd_s i_cmd,
    // cancel of the request now on the port
    input wire logic i_cancel,
    output logic o_req_pending,
    // responses to user logic
    output logic o_rsp_valid,
    output logic o_rsp_write,
    output logic o_rsp_abort,
    output logic [cdmp_pkg::DATA_W-1:0] o_rsp_rdata,
    // debug halt
    input wire logic i_debug_resume,
    output logic o_debug_halt,
    // memory port
    cdmp_if.core bus
);
    cdmp_pkg::cdmp_cmd_s head;
    logic head_valid;
    logic fifo_ready;
    logic run;
    logic take;
    logic in_burst_reg;
    logic dphase_reg;
    logic dwrite_reg;
    logic [cdmp_pkg::DATA_W-1:0] dwdata_reg;
    logic [cdmp_pkg::SIZE_W-1:0] size_next;

    // port state advances only on enabled cycles; fifo fill and halt resume act on any cycle
    assign run = bus.cycle_stall_en;
    // a new burst waits while halted; beats of a started burst go on
    assign take = run && head_valid && (!o_debug_halt || in_burst_reg);
    assign o_cmd_ready = fifo_ready;
    // reserved size code is never put on the port
    assign size_next = (head.size == cdmp_pkg::SIZE_RSVD) ? cdmp_pkg::SIZE_WORD : head.size;

    cdmp_fifo #(
        .WIDTH(cdmp_pkg::CMD_W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .i_in_valid(i_cmd_valid),
        .o_in_ready(fifo_ready),
        .i_in_data(i_cmd),
        .o_out_valid(head_valid),
        .i_out_ready(take),
        .o_out_data(head)
    );

    // address phase: announce the next-cycle access
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            bus.mem_addr_out <= '0;
            bus.request_n_out <= cdmp_pkg::REQ_IDLE_N;
            bus.write_not_read_out <= 1'b0;
            bus.access_size_out <= cdmp_pkg::SIZE_WORD;
            bus.sequential_out <= 1'b0;
            bus.burst_continue_out <= 1'b0;
            bus.bus_lock_out <= 1'b0;
            bus.speculative_hint_n_out <= cdmp_pkg::SPEC_IDLE_N;
            bus.user_priv_n_out <= cdmp_pkg::PRIV_RST_N;
            bus.proc_mode_out <= cdmp_pkg::MODE_RST;
            bus.burst_length_out <= '0;
            in_burst_reg <= 1'b0;
        end else if (take) begin
            bus.mem_addr_out <= head.addr;
            bus.request_n_out <= head.spec;
            bus.speculative_hint_n_out <= !head.spec;
            bus.write_not_read_out <= head.write && !head.spec;
            bus.access_size_out <= size_next;
            bus.sequential_out <= in_burst_reg && !head.spec;
            bus.burst_continue_out <= head.more && !head.spec;
            bus.bus_lock_out <= head.lock;
            bus.user_priv_n_out <= head.user_n;
            bus.proc_mode_out <= head.mode;
            bus.burst_length_out <= head.burst_len;
            in_burst_reg <= head.more && !head.spec;
        end else if (run) begin
            // nothing to issue: idle, lock and mode left as they were
            bus.request_n_out <= cdmp_pkg::REQ_IDLE_N;
            bus.speculative_hint_n_out <= cdmp_pkg::SPEC_IDLE_N;
            bus.sequential_out <= 1'b0;
            bus.burst_continue_out <= 1'b0;
        end
    end

    // remember the beat on the port for its data phase
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            dphase_reg <= 1'b0;
            dwrite_reg <= 1'b0;
            dwdata_reg <= '0;
            bus.cancel_prev_out <= 1'b0;
        end else if (run) begin
            dphase_reg <= !bus.request_n_out;
            dwrite_reg <= bus.write_not_read_out;
            dwdata_reg <= take ? head.wdata : dwdata_reg;
            bus.cancel_prev_out <= i_cancel && !bus.request_n_out;
        end
    end

    // write word stands only in write data phases
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            bus.wdata <= '0;
        end else if (run) begin
            bus.wdata <= (!bus.request_n_out && bus.write_not_read_out) ? dwdata_reg : '0;
        end
    end

    // data phase end: sample memory answers
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rsp_valid <= 1'b0;
            o_rsp_write <= 1'b0;
            o_rsp_abort <= 1'b0;
            o_rsp_rdata <= '0;
        end else begin
            o_rsp_valid <= run && dphase_reg && !bus.cancel_prev_out;
            if (run && dphase_reg) begin
                o_rsp_write <= dwrite_reg;
                o_rsp_abort <= bus.access_abort_in;
                o_rsp_rdata <= dwrite_reg ? '0 : bus.rdata;
            end
        end
    end

    // halt on watchpoint; a hit beats a resume in the same cycle
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_debug_halt <= 1'b0;
        end else if (run && dphase_reg && bus.watchpoint_hit_in) begin
            o_debug_halt <= 1'b1;
        end else if (i_debug_resume) begin
            o_debug_halt <= 1'b0;
        end
    end

    // registered copy of the request for the user cancel window
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_req_pending <= 1'b0;
        end else if (run) begin
            o_req_pending <= take && !head.spec;
        end
    end
endmodule
`default_nettype wire

// ---- shared/cdmp_pkg.sv ----
// Purpose: shared constants and types for the data memory port, both ends
// Assumes: one 20 MHz clock, little-endian byte lanes on the memory side
// Notes: command words cross the core-end fifo as one packed struct
package cdmp_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int MODE_W = 5;
    localparam int BURST_W = 4;
    localparam int SIZE_W = 2;
    localparam int FIFO_DEPTH = 8;
    localparam int MEM_WORDS = 256;
    localparam int CLK_HZ = 20000000;
    // access size codes
    localparam logic [SIZE_W-1:0] SIZE_BYTE = 2'h0;
    localparam logic [SIZE_W-1:0] SIZE_HALF = 2'h1;
    localparam logic [SIZE_W-1:0] SIZE_WORD = 2'h2;
    localparam logic [SIZE_W-1:0] SIZE_RSVD = 2'h3;
    // idle and reset levels of the interface
    localparam logic REQ_IDLE_N = 1'b1;
    localparam logic SPEC_IDLE_N = 1'b1;
    localparam logic PRIV_RST_N = 1'b1;
    localparam logic [MODE_W-1:0] MODE_RST = 5'h13;
    localparam logic [1:0] LANE_LSB = 2'h0;
    localparam int WORD_LSB = 2;
    // one command word as queued by the core user
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic write;
        logic [SIZE_W-1:0] size;
        logic [MODE_W-1:0] mode;
        logic user_n;
        logic lock;
        logic spec;
        logic more;
        logic [BURST_W-1:0] burst_len;
    } cdmp_cmd_s;
    localparam int CMD_W = $bits(cdmp_cmd_s);
endpackage

// ---- shared/cdmp_if.sv ----
// Purpose: wires between the core end and the memory end of the data port
// Assumes: every signal is driven and sampled on the rising edge of one clock
// Notes: no clocking block; the testbench joins both ends through this
`timescale 1ns/1ps
`default_nettype none
interface cdmp_if;
    // core to memory
    logic [cdmp_pkg::ADDR_W-1:0] mem_addr_out;
    logic request_n_out;
    logic write_not_read_out;
    logic [cdmp_pkg::SIZE_W-1:0] access_size_out;
    logic sequential_out;
    logic burst_continue_out;
    logic bus_lock_out;
    logic speculative_hint_n_out;
    logic user_priv_n_out;
    logic [cdmp_pkg::MODE_W-1:0] proc_mode_out;
    logic cancel_prev_out;
    logic [cdmp_pkg::BURST_W-1:0] burst_length_out;
    logic [cdmp_pkg::DATA_W-1:0] wdata;
    // memory to core
    logic [cdmp_pkg::DATA_W-1:0] rdata;
    logic access_abort_in;
    logic watchpoint_hit_in;
    logic cycle_stall_en;

    modport core (
        output mem_addr_out, request_n_out, write_not_read_out, access_size_out,
        output sequential_out, burst_continue_out, bus_lock_out, speculative_hint_n_out,
        output user_priv_n_out, proc_mode_out, cancel_prev_out, burst_length_out, wdata,
        input rdata, access_abort_in, watchpoint_hit_in, cycle_stall_en
    );
    modport mem (
        input mem_addr_out, request_n_out, write_not_read_out, access_size_out,
        input sequential_out, burst_continue_out, bus_lock_out, speculative_hint_n_out,
        input user_priv_n_out, proc_mode_out, cancel_prev_out, burst_length_out, wdata,
        output rdata, access_abort_in, watchpoint_hit_in, cycle_stall_en
    );
endinterface
`default_nettype wire

// ---- verilog/cdmp_mem_end.sv ----
// Purpose: memory end of the data port: word array, stall, abort, lock grant
// Assumes: shares i_ref_clk with the core end; little-endian byte lanes
// Notes: accesses beyond the array abort; another requester is granted when free
`timescale 1ns/1ps
`default_nettype none
module cdmp_mem_end #(
    parameter int WORDS = cdmp_pkg::MEM_WORDS
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    // user stall and watchpoint controls
    input wire logic i_stall_req,
    input wire logic i_wpt_req,
    // another requester of the memory
    input wire logic i_other_req,
    output logic o_other_gnt,
    output logic o_locked,
    // memory port
    cdmp_if.mem bus
);
    localparam int IDX_W = $clog2(WORDS);
    logic [cdmp_pkg::DATA_W-1:0] mem_reg [WORDS];
    logic seen;
    logic in_range;
    logic [IDX_W-1:0] idx;
    logic wr_pend_reg;
    logic [IDX_W-1:0] wr_idx_reg;
    logic [3:0] wr_be_reg;
    logic [3:0] be;
    logic [cdmp_pkg::DATA_W-1:0] rd_word;

    assign seen = bus.cycle_stall_en && !bus.request_n_out;
    assign idx = bus.mem_addr_out[cdmp_pkg::WORD_LSB +: IDX_W];
    assign in_range = (bus.mem_addr_out >> (cdmp_pkg::WORD_LSB + IDX_W)) == '0;

    // byte enables from size and low address bits
    always_comb begin
        unique case (bus.access_size_out)
            cdmp_pkg::SIZE_BYTE: be = 4'h1 << bus.mem_addr_out[1:0];
            cdmp_pkg::SIZE_HALF: be = bus.mem_addr_out[1] ? 4'hc : 4'h3;
            default: be = 4'hf;
        endcase
    end

    // read word with a write landing at this same edge merged in, so back to back read after write is fresh
    always_comb begin
        rd_word = mem_reg[idx];
        for (int b = 0; b < 4; b++) begin
            if (wr_pend_reg && !bus.cancel_prev_out && wr_idx_reg == idx && wr_be_reg[b]) begin
                rd_word[b*8 +: 8] = bus.wdata[b*8 +: 8];
            end
        end
    end

    // stall only on request; idle level is high
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            bus.cycle_stall_en <= 1'b1;
        end else begin
            bus.cycle_stall_en <= !i_stall_req;
        end
    end

    // answer for the data phase; speculative hints are never aborted
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            bus.rdata <= '0;
            bus.access_abort_in <= 1'b0;
            bus.watchpoint_hit_in <= 1'b0;
        end else if (bus.cycle_stall_en) begin
            bus.rdata <= (seen && !bus.write_not_read_out && in_range) ? rd_word : '0;
            bus.access_abort_in <= seen && !in_range;
            bus.watchpoint_hit_in <= seen && i_wpt_req;
        end
    end

    // write commits at the end of its data phase unless cancelled
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_pend_reg <= 1'b0;
            wr_idx_reg <= '0;
            wr_be_reg <= '0;
        end else if (bus.cycle_stall_en) begin
            wr_pend_reg <= seen && bus.write_not_read_out && in_range;
            wr_idx_reg <= idx;
            wr_be_reg <= be;
        end
    end

    // byte lane merge into the array
    always_ff @(posedge i_ref_clk) begin
        if (bus.cycle_stall_en && wr_pend_reg && !bus.cancel_prev_out) begin
            for (int b = 0; b < 4; b++) begin
                if (wr_be_reg[b]) begin
                    mem_reg[wr_idx_reg][b*8 +: 8] <= bus.wdata[b*8 +: 8];
                end
            end
        end
    end

    // grant others only when the core neither locks nor requests
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_other_gnt <= 1'b0;
            o_locked <= 1'b0;
        end else begin
            o_locked <= bus.bus_lock_out;
            o_other_gnt <= i_other_req && !bus.bus_lock_out && bus.request_n_out;
        end
    end
endmodule
`default_nettype wire

// ---- test/cdmp_asserts.sv ----
// Purpose: wire checks between the core end and the memory end
// Assumes: one clock, asynchronous reset active low
// Notes: instantiated beside the interface by the testbench
`timescale 1ns/1ps
`default_nettype none
module cdmp_asserts #(
    parameter int WORDS = cdmp_pkg::MEM_WORDS
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    // core to memory
    input wire logic [cdmp_pkg::ADDR_W-1:0] mem_addr_out,
    input wire logic request_n_out,
    input wire logic write_not_read_out,
    input wire logic [cdmp_pkg::SIZE_W-1:0] access_size_out,
    input wire logic sequential_out,
    input wire logic burst_continue_out,
    input wire logic speculative_hint_n_out,
    input wire logic [cdmp_pkg::MODE_W-1:0] proc_mode_out,
    input wire logic cancel_prev_out,
    // memory to core
    input wire logic access_abort_in,
    input wire logic cycle_stall_en
);
    localparam logic [31:0] LIMIT = 32'(WORDS * 4);
    logic last_more_reg;
    logic take;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);
    // request taken by the memory at this edge
    assign take = !request_n_out && cycle_stall_en;
    // more flag of the last taken beat
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            last_more_reg <= 1'b0;
        end else if (take) begin
            last_more_reg <= burst_continue_out;
        end
    end
    chk_size_legal: assert property (!request_n_out |-> access_size_out != cdmp_pkg::SIZE_RSVD)
        else $error("reserved size on a request");
    chk_spec_apart: assert property (!speculative_hint_n_out |-> request_n_out)
        else $error("hint together with a request");
    chk_stall_hold: assert property (!cycle_stall_en |=> $stable(mem_addr_out) && $stable(request_n_out)
        && $stable(access_size_out) && $stable(write_not_read_out)) else $error("port moved while stalled");
    chk_spec_no_abort: assert property (!speculative_hint_n_out && cycle_stall_en |=> !access_abort_in)
        else $error("abort after a hint");
    chk_abort_far: assert property (take && mem_addr_out >= LIMIT |=> access_abort_in)
        else $error("no abort beyond the array");
    chk_abort_near: assert property (take && mem_addr_out < LIMIT |=> !access_abort_in)
        else $error("abort inside the array");
    chk_cancel_after_req: assert property ($rose(cancel_prev_out) |-> $past(request_n_out) == 1'b0)
        else $error("cancel without a request before");
    chk_seq_after_more: assert property (!request_n_out && sequential_out |-> last_more_reg)
        else $error("sequential without a more beat");
    chk_reset_idle: assert property ($rose(i_rst_b) |-> request_n_out && speculative_hint_n_out
        && proc_mode_out == cdmp_pkg::MODE_RST) else $error("port not idle after reset");
    // main scenarios
    cov_write: cover property (take && write_not_read_out);
    cov_cancel: cover property ($rose(cancel_prev_out));
    cov_stall: cover property (!request_n_out && !cycle_stall_en);
endmodule
`default_nettype wire

// ---- test/tb_cpu_data_memory_port.sv ----
// Purpose: both ends joined, driven from the user sides
// Assumes: 20 MHz clock, memory content unknown until written
// Notes: responses and port activity are gathered at falling edges
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_data_memory_port;
    localparam logic [3:0] W = 4'h8, M = 4'h4, S = 4'h2, L = 4'h1;
    localparam logic [31:0] FAR = 32'(cdmp_pkg::MEM_WORDS * 4);
    logic i_ref_clk = 1'b0, i_rst_b = 1'b0, i_cmd_valid = 1'b0, i_cancel = 1'b0;
    logic i_debug_resume = 1'b0, i_stall_req = 1'b0, i_wpt_req = 1'b0, i_other_req = 1'b0;
    cdmp_pkg::cdmp_cmd_s i_cmd = '0;
    logic o_cmd_ready, o_req_pending, o_rsp_valid, o_rsp_write, o_rsp_abort, o_debug_halt;
    logic o_other_gnt, o_locked;
    logic [31:0] o_rsp_rdata;
    logic [33:0] rq[$];
    logic [9:0] last_mode;
    int fail_count = 0, tests_run = 0, n_req, n_seq, n_more, n_spec, n_cancel;
    cdmp_if link();
    cdmp_core_end #(.DEPTH(cdmp_pkg::FIFO_DEPTH)) cdmp_core_end_inst (.i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b), .i_cmd_valid(i_cmd_valid), .o_cmd_ready(o_cmd_ready), .i_cmd(i_cmd),
        .i_cancel(i_cancel), .o_req_pending(o_req_pending), .o_rsp_valid(o_rsp_valid),
        .o_rsp_write(o_rsp_write), .o_rsp_abort(o_rsp_abort), .o_rsp_rdata(o_rsp_rdata),
        .i_debug_resume(i_debug_resume), .o_debug_halt(o_debug_halt), .bus(link));
    cdmp_mem_end #(.WORDS(cdmp_pkg::MEM_WORDS)) cdmp_mem_end_inst (.i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b), .i_stall_req(i_stall_req), .i_wpt_req(i_wpt_req), .i_other_req(i_other_req),
        .o_other_gnt(o_other_gnt), .o_locked(o_locked), .bus(link));
    cdmp_asserts #(.WORDS(cdmp_pkg::MEM_WORDS)) cdmp_asserts_inst (.i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b), .mem_addr_out(link.mem_addr_out), .request_n_out(link.request_n_out),
        .write_not_read_out(link.write_not_read_out), .access_size_out(link.access_size_out),
        .sequential_out(link.sequential_out), .burst_continue_out(link.burst_continue_out),
        .speculative_hint_n_out(link.speculative_hint_n_out), .proc_mode_out(link.proc_mode_out),
        .cancel_prev_out(link.cancel_prev_out), .access_abort_in(link.access_abort_in),
        .cycle_stall_en(link.cycle_stall_en));
    // clock
    always #25 i_ref_clk = ~i_ref_clk;
    // gather responses and port activity where settled
    always @(negedge i_ref_clk) begin
        if (o_rsp_valid === 1'b1) rq.push_back({o_rsp_write, o_rsp_abort, o_rsp_rdata});
        if (link.request_n_out === 1'b0 && link.cycle_stall_en === 1'b1) begin
            n_req++;
            n_seq += int'(link.sequential_out === 1'b1);
            n_more += int'(link.burst_continue_out === 1'b1);
            last_mode = {link.burst_length_out, link.user_priv_n_out, link.proc_mode_out};
        end
        n_spec += int'(link.speculative_hint_n_out === 1'b0);
        n_cancel += int'(link.cancel_prev_out === 1'b1);
    end
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // start a scenario one edge on with clean counters
    task automatic clr();
        @(posedge i_ref_clk);
        {n_req, n_seq, n_more, n_spec, n_cancel} = '0;
        rq.delete();
    endtask
    // offer one beat and hold it until taken; valid stays up
    task automatic push(input logic [31:0] a, input logic [31:0] d, input logic [1:0] sz, input logic [3:0] f);
        #1;
        i_cmd = '{addr:a, wdata:d, write:f[3], size:sz, mode:5'h10, user_n:1'b0, lock:f[0], spec:f[1],
            more:f[2], burst_len:4'h4};
        i_cmd_valid = 1'b1;
        @(posedge i_ref_clk);
        while (o_cmd_ready !== 1'b1) @(posedge i_ref_clk);
    endtask
    task automatic done();
        #1 i_cmd_valid = 1'b0;
        @(posedge i_ref_clk);
    endtask
    // next response, data compared only when cd is set
    task automatic rsp(input logic w, input logic ab, input logic [31:0] d, input logic cd);
        logic [33:0] r;
        int n = 0;
        while (rq.size() == 0 && n < 40) begin
            @(negedge i_ref_clk);
            n++;
        end
        r = (rq.size() > 0) ? rq.pop_front() : 'x;
        check(r, {w, ab, cd ? d : r[31:0]});
    endtask
    task automatic s_rw();
        clr();
        push(32'h10, 32'h11223344, cdmp_pkg::SIZE_WORD, W);
        push(32'h13, 32'haaaaaaaa, cdmp_pkg::SIZE_BYTE, W);
        push(32'h10, 32'h0, cdmp_pkg::SIZE_WORD, 4'h0);
        push(32'h10, 32'hbbbbbbbb, cdmp_pkg::SIZE_HALF, W);
        push(32'h10, 32'h0, cdmp_pkg::SIZE_RSVD, 4'h0);
        push(FAR, 32'h0, cdmp_pkg::SIZE_WORD, 4'h0);
        done();
        rsp(1'b1, 1'b0, 32'h0, 1'b0);
        rsp(1'b1, 1'b0, 32'h0, 1'b0);
        rsp(1'b0, 1'b0, 32'haa223344, 1'b1);
        rsp(1'b1, 1'b0, 32'h0, 1'b0);
        rsp(1'b0, 1'b0, 32'haa22bbbb, 1'b1);
        rsp(1'b0, 1'b1, 32'h0, 1'b0);
        check(n_req, 6);
    endtask
    task automatic s_burst();
        clr();
        for (int i = 0; i < 4; i++) push(32'h20 + 4 * i, 32'h100 + i, cdmp_pkg::SIZE_WORD, (i < 3) ? W | M : W);
        for (int i = 0; i < 4; i++) push(32'h20 + 4 * i, 32'h0, cdmp_pkg::SIZE_WORD, (i < 3) ? M : 4'h0);
        done();
        for (int i = 0; i < 4; i++) rsp(1'b1, 1'b0, 32'h0, 1'b0);
        for (int i = 0; i < 4; i++) rsp(1'b0, 1'b0, 32'h100 + i, 1'b1);
        check(n_seq, 6);
        check(n_more, 6);
        check(last_mode, {4'h4, 1'b0, 5'h10});
    endtask
    task automatic s_stall_cancel();
        clr();
        push(32'h20, 32'h0, cdmp_pkg::SIZE_WORD, 4'h0);
        #1 i_cmd_valid = 1'b0;
        i_stall_req = 1'b1;
        repeat (4) @(posedge i_ref_clk);
        #1 i_stall_req = 1'b0;
        rsp(1'b0, 1'b0, 32'h100, 1'b1);
        check(n_req, 1);
        clr();
        push(32'h24, 32'hdeadbeef, cdmp_pkg::SIZE_WORD, W);
        done();
        #1 check(o_req_pending, 1'b1);
        i_cancel = 1'b1;
        @(posedge i_ref_clk);
        #1 i_cancel = 1'b0;
        repeat (8) @(posedge i_ref_clk);
        check(rq.size(), 0);
        check(n_cancel, 1);
        push(32'h24, 32'h0, cdmp_pkg::SIZE_WORD, 4'h0);
        done();
        rsp(1'b0, 1'b0, 32'h101, 1'b1);
    endtask
    task automatic s_spec_lock();
        clr();
        push(32'h28, 32'h0, cdmp_pkg::SIZE_WORD, S);
        done();
        repeat (8) @(posedge i_ref_clk);
        check({rq.size() == 0, n_req == 0, n_spec != 0}, 3'h7);
        push(32'h20, 32'h0, cdmp_pkg::SIZE_WORD, L);
        done();
        #1 i_other_req = 1'b1;
        repeat (6) @(posedge i_ref_clk);
        check({o_other_gnt, o_locked}, 2'h1);
        push(32'h20, 32'h0, cdmp_pkg::SIZE_WORD, 4'h0);
        done();
        rsp(1'b0, 1'b0, 32'h100, 1'b1);
        rsp(1'b0, 1'b0, 32'h100, 1'b1);
        repeat (3) @(posedge i_ref_clk);
        check({o_other_gnt, o_locked}, 2'h2);
        #1 i_other_req = 1'b0;
    endtask
    task automatic s_fill_wpt();
        int n = 0;
        logic r;
        clr();
        #1 i_stall_req = 1'b1;
        repeat (2) @(posedge i_ref_clk);
        push(32'h2c, 32'h0, cdmp_pkg::SIZE_WORD, 4'h0);
        repeat (14) begin
            r = o_cmd_ready;
            @(posedge i_ref_clk);
            n += int'(r === 1'b1);
            #1;
        end
        check({o_cmd_ready, n == cdmp_pkg::FIFO_DEPTH - 1}, 2'h1);
        i_cmd_valid = 1'b0;
        i_stall_req = 1'b0;
        repeat (n + 1) rsp(1'b0, 1'b0, 32'h103, 1'b1);
        clr();
        push(32'h20, 32'h0, cdmp_pkg::SIZE_WORD, 4'h0);
        done();
        #1 i_wpt_req = 1'b1;
        rsp(1'b0, 1'b0, 32'h100, 1'b1);
        @(posedge i_ref_clk);
        #1 i_wpt_req = 1'b0;
        repeat (3) @(posedge i_ref_clk);
        check(o_debug_halt, 1'b1);
        #1 i_debug_resume = 1'b1;
        @(posedge i_ref_clk);
        #1 i_debug_resume = 1'b0;
        repeat (2) @(posedge i_ref_clk);
        check(o_debug_halt, 1'b0);
    endtask
    // reset, then the scenarios
    initial begin
        repeat (10) @(posedge i_ref_clk);
        #1 i_rst_b = 1'b1;
        s_rw();
        s_burst();
        s_stall_cancel();
        s_spec_lock();
        s_fill_wpt();
        complete_run();
    end
    // cut a hang short
    initial begin
        #2000000;
        fail_count++;
        complete_run();
    end
endmodule
`default_nettype wire
